// file: rtl/cfg_pin_params.svh
/*
 Constants for the configuration pin controller: state timing, readback frame sizes
 and reset values. Included by design and testbench files by bare name.
*/
`ifndef CFG_PIN_PARAMS_SVH
`define CFG_PIN_PARAMS_SVH
`define FRAME_COUNT 16'h0010
`define FRAME_BITS 16'h0020
`define STROBE_DIV 8'h04
`define OPT_DONE_DELAY_RST 4'h2
`define OPT_IO_DELAY_RST 4'h3
`define LOAD_BITS 16'h0200
`endif

// file: rtl/cfg_pin_pkg.sv
/*
 Types for the configuration pin controller.
 Assumes cfg_pin_params.svh is on the include path.
*/
package cfg_pin_pkg;
    typedef enum logic [2:0] {
        ST_CLEAR = 3'b000,
        ST_LOAD = 3'b001,
        ST_WAIT_DONE = 3'b010,
        ST_RELEASE = 3'b011,
        ST_USER = 3'b100
    } cfg_state_t;
    typedef enum logic [1:0] {
        MODE_MASTER = 2'b00,
        MODE_ASYNC_PERIPH = 2'b01,
        MODE_SLAVE = 2'b10,
        MODE_BUS = 2'b11
    } cfg_mode_t;
    typedef struct packed {
        logic tristate_after;
        logic readback_en;
        logic [3:0] done_delay;
        logic [3:0] io_delay;
    } cfg_opts_t;
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;
endpackage

// file: rtl/pin_sync.sv
/*
 Two-flop synchroniser for a vector of asynchronous pins.
 Assumes clk is the block clock; first stage is read only by the second.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,           // Block clock
    input wire logic [W-1:0] d,     // Asynchronous inputs
    output logic [W-1:0] q          // Synchronised outputs
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk) begin
        meta_reg <= d;
        q <= meta_reg;
    end
endmodule
`default_nettype wire

// file: rtl/fpga_config_pin_control.sv
/*
 Configuration pin control: restart, strobe clock direction, completion and start-up
 handshake, global tri-state, readback shift-out and error/interrupt pin.
 Assumes the configuration datapath reports load progress and init errors, and that
 pins arrive from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cfg_pin_params.svh"
module fpga_config_pin_control (
    input wire logic clk,                       // Block clock, 125 MHz
    input wire logic sys_rst,                   // Synchronous reset, active high
    input wire logic ce,                        // Clock enable, freezes state when low
    input wire logic [3:0] addr,                // Register address
    input wire logic [31:0] wdata,              // Register write data
    input wire logic wr,                        // Write strobe
    input wire logic rd,                        // Read strobe
    output logic [31:0] rdata,                  // Read data, cycle after strobe
    input wire logic reset_pin,                 // Reset pin
    input wire logic program_restart_n,         // Program restart pin, active low
    input wire logic rd_cfg_n,                  // Readback/tri-state control pin
    input wire logic [1:0] mode_pins,           // Configuration mode
    input wire logic lead_device,               // Device leads a daisy chain
    input wire logic config_strobe_clock_i,     // Strobe clock pin input
    output logic config_strobe_clock_o,         // Strobe clock pin output
    output logic config_strobe_clock_oe,        // Strobe clock pin enable
    input wire logic done_i,                    // Completion pin level
    output logic done_o,                        // Completion pin output (always 0)
    output logic done_oe,                       // Completion pin pull-low enable
    output logic init_status,                   // Initialisation status high when ready
    input wire logic load_bit,                  // One configuration bit taken
    input wire logic init_error,                // RAM or core init failure
    input wire logic jtag_active,               // Boundary scan in use
    input wire logic tdo_data,                  // Boundary scan test data
    input wire logic [15:0] frame_data,         // Readback word at frame_addr
    output logic [15:0] frame_addr,             // Readback frame address
    output logic rd_data_tdo,                   // Shared readback / test data pin
    input wire logic host_irq_req,              // Host port interrupt request
    output logic cfg_irq_n,                     // Error / host port interrupt, low
    input wire logic [7:0] unused_pins,         // Pins marked unused or unbonded
    output logic user_io_enable,                // User I/O may be driven
    output logic [7:0] io_pullup,               // Pull-up enable per pin group
    output logic global_tristate,               // Force all I/O high impedance
    output logic global_set_reset,              // Async set/reset to logic cells
    output logic user_reset_in,                 // Reset pin as general input
    output logic jtag_reset                     // Boundary scan reset
);
    logic [4:0] sync_q;
    logic rst_s, prg_n_s, rdcfg_s, sclk_s, done_s;
    logic sclk_d_reg, rdcfg_d_reg;
    logic sclk_rise, rdcfg_fall, restart;
    cfg_pin_pkg::cfg_state_t state_reg, state_next;
    cfg_pin_pkg::cfg_opts_t opts_reg;
    logic reset_as_gsr_reg;
    logic [15:0] load_cnt_reg, bit_cnt_reg;
    logic [3:0] delay_cnt_reg;
    logic [7:0] div_reg;
    logic sclk_gen_reg, readback_reg, err_reg, reload_reg;
    logic [15:0] shift_reg;
    logic in_config, drive_clk, rb_step;

    pin_sync #(.W(5)) u_sync (
        .clk(clk),
        .d({reset_pin, program_restart_n, rd_cfg_n, config_strobe_clock_i, done_i}),
        .q(sync_q)
    );
    assign {rst_s, prg_n_s, rdcfg_s, sclk_s, done_s} = sync_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_d_reg <= 1'b0;
            rdcfg_d_reg <= 1'b1;
        end else if (ce) begin
            sclk_d_reg <= sclk_s;
            rdcfg_d_reg <= rdcfg_s;
        end
    end
    assign sclk_rise = sclk_s && !sclk_d_reg;
    assign rdcfg_fall = rdcfg_d_reg && !rdcfg_s;

    assign in_config = (state_reg != cfg_pipeline_user());
    function automatic cfg_pin_pkg::cfg_state_t cfg_pipeline_user();
        return cfg_pin_pkg::ST_USER;
    endfunction

    assign restart = !prg_n_s || (rst_s && in_config);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cfg_pin_pkg::ST_CLEAR: begin
                if (rdcfg_s) begin
                    state_next = cfg_pin_pkg::ST_LOAD;
                end
            end
            cfg_pin_pkg::ST_LOAD: begin
                if (load_cnt_reg == `LOAD_BITS) begin
                    state_next = cfg_pin_pkg::ST_WAIT_DONE;
                end
            end
            cfg_pin_pkg::ST_WAIT_DONE: begin
                if (delay_cnt_reg == 4'h0 && done_s) begin
                    state_next = cfg_pin_pkg::ST_RELEASE;
                end
            end
            cfg_pin_pkg::ST_RELEASE: begin
                if (delay_cnt_reg == 4'h0) begin
                    state_next = cfg_pin_pkg::ST_USER;
                end
            end
            cfg_pin_pkg::ST_USER: begin
                state_next = cfg_pin_pkg::ST_USER;
            end
            default: begin
                state_next = cfg_pin_pkg::ST_CLEAR;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= cfg_pin_pkg::ST_CLEAR;
        end else if (ce) begin
            if (restart) begin
                state_reg <= cfg_pin_pkg::ST_CLEAR;
            end else begin
                state_reg <= state_next;
            end
        end
    end

    // Load progress, counted in load_bit pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            load_cnt_reg <= 16'h0000;
        end else if (ce) begin
            if (restart || state_reg != cfg_pin_pkg::ST_LOAD) begin
                load_cnt_reg <= 16'h0000;
            end else if (load_bit && load_cnt_reg != `LOAD_BITS) begin
                load_cnt_reg <= load_cnt_reg + 16'h0001;
            end
        end
    end

    // Start-up delays, counted in strobe clock periods
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            delay_cnt_reg <= 4'h0;
        end else if (ce) begin
            if (state_reg == cfg_pin_pkg::ST_LOAD) begin
                delay_cnt_reg <= opts_reg.done_delay;
            end else if (state_reg == cfg_pin_pkg::ST_WAIT_DONE && state_next
                    == cfg_pin_pkg::ST_RELEASE) begin
                delay_cnt_reg <= opts_reg.io_delay;
            end else if (sclk_rise && delay_cnt_reg != 4'h0) begin
                delay_cnt_reg <= delay_cnt_reg - 4'h1;
            end
        end
    end

    // Strobe clock divider for modes where this device drives it
    assign drive_clk = (mode_pins == cfg_pin_pkg::MODE_MASTER)
        || (mode_pins == cfg_pin_pkg::MODE_ASYNC_PERIPH)
        || (lead_device && mode_pins != cfg_pin_pkg::MODE_SLAVE);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_reg <= 8'h00;
            sclk_gen_reg <= 1'b0;
        end else if (ce) begin
            if (div_reg == `STROBE_DIV - 8'h01) begin
                div_reg <= 8'h00;
                sclk_gen_reg <= !sclk_gen_reg;
            end else begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end
    // Readback always takes the strobe clock from outside
    assign config_strobe_clock_oe = drive_clk && in_config;
    assign config_strobe_clock_o = sclk_gen_reg;

    assign done_o = 1'b0;
    assign done_oe = (state_reg == cfg_pin_pkg::ST_CLEAR)
        || (state_reg == cfg_pin_pkg::ST_LOAD)
        || (state_reg == cfg_pin_pkg::ST_WAIT_DONE && delay_cnt_reg != 4'h0);
    assign init_status = (state_reg != cfg_pin_pkg::ST_CLEAR);

    // Readback engine
    assign rb_step = readback_reg && sclk_rise;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readback_reg <= 1'b0;
            frame_addr <= 16'h0000;
            bit_cnt_reg <= 16'h0000;
            shift_reg <= 16'h0000;
            reload_reg <= 1'b0;
        end else if (ce) begin
            reload_reg <= 1'b0;
            if (in_config) begin
                readback_reg <= 1'b0;
            end else if (!readback_reg && opts_reg.readback_en && rdcfg_fall) begin
                readback_reg <= 1'b1;
                frame_addr <= 16'h0000;
                bit_cnt_reg <= 16'h0000;
                // Frame word follows the new address one cycle later
                reload_reg <= 1'b1;
            end else if (rb_step) begin
                shift_reg <= {shift_reg[14:0], 1'b0};
                if (bit_cnt_reg == `FRAME_BITS - 16'h0001) begin
                    bit_cnt_reg <= 16'h0000;
                    if (frame_addr == `FRAME_COUNT - 16'h0001) begin
                        readback_reg <= 1'b0;
                    end else begin
                        frame_addr <= frame_addr + 16'h0001;
                        reload_reg <= 1'b1;
                    end
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 16'h0001;
                    if (bit_cnt_reg[3:0] == 4'hF) begin
                        shift_reg <= frame_data;
                    end
                end
            end else if (reload_reg) begin
                shift_reg <= frame_data;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_tdo <= 1'b0;
        end else if (ce) begin
            rd_data_tdo <= jtag_active ? tdo_data : shift_reg[15];
        end
    end

    // Init error latch and shared interrupt pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            err_reg <= 1'b0;
            cfg_irq_n <= 1'b1;
        end else if (ce) begin
            if (init_error && in_config) begin
                err_reg <= 1'b1;
            end else if (restart) begin
                err_reg <= 1'b0;
            end
            cfg_irq_n <= in_config ? !(err_reg || init_error) : !host_irq_req;
        end
    end

    // I/O control
    assign user_io_enable = (state_reg == cfg_pin_pkg::ST_USER) && !global_tristate;
    // Global tri-state also pulls every pin group up
    assign io_pullup = (in_config || global_tristate) ? 8'hFF : unused_pins;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            global_tristate <= 1'b1;
        end else if (ce) begin
            if (in_config) begin
                global_tristate <= !rdcfg_s || state_reg != cfg_pin_pkg::ST_USER;
            end else begin
                global_tristate <= opts_reg.tristate_after && !rdcfg_s;
            end
        end
    end
    assign global_set_reset = !in_config && reset_as_gsr_reg && rst_s;
    assign user_reset_in = !in_config && !reset_as_gsr_reg && rst_s;
    assign jtag_reset = !prg_n_s;

    // Option register: offset 0 options, offset 1 status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opts_reg <= '{1'b0, 1'b0, `OPT_DONE_DELAY_RST, `OPT_IO_DELAY_RST};
            reset_as_gsr_reg <= 1'b0;
        end else if (ce && wr && addr == 4'h0) begin
            opts_reg <= wdata[9:0];
            reset_as_gsr_reg <= wdata[10];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            if (rd && addr == 4'h0) begin
                rdata <= {21'h000000, reset_as_gsr_reg, opts_reg};
            end else if (rd && addr == 4'h1) begin
                rdata <= {frame_addr, 11'h000, err_reg, readback_reg, state_reg};
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/cfg_pin_asserts.sv
/*
 Port assertions for the configuration pin controller.
 Assumes one clock domain, sys_rst synchronous and active high.
*/
`timescale 1ns/1ns
`default_nettype none
module cfg_pin_asserts (
    input wire logic clk,                       // Block clock
    input wire logic sys_rst,                   // Reset
    input wire logic rd,                        // Read strobe
    input wire logic [31:0] rdata,              // Read data
    input wire logic [1:0] mode_pins,           // Mode
    input wire logic lead_device,               // Chain lead
    input wire logic config_strobe_clock_oe,    // Strobe enable
    input wire logic done_o,                    // Completion out
    input wire logic done_oe,                   // Completion pull-low
    input wire logic user_io_enable,            // User I/O live
    input wire logic [7:0] io_pullup,           // Pull-ups
    input wire logic [7:0] unused_pins,         // Unused pins
    input wire logic program_restart_n,         // Restart pin
    input wire logic jtag_reset,                // Scan reset
    input wire logic rd_cfg_n,                  // Readback control
    input wire logic global_tristate            // Global tri-state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_cfg_pullup_all: assert property (!user_io_enable |-> io_pullup == 8'hFF)
        else $error("pull-ups off during configuration");
    a_user_pullup_unused: assert property (user_io_enable |-> io_pullup == unused_pins)
        else $error("unused pin pull-ups wrong");
    a_master_drives_strobe: assert property (
        (mode_pins[1] == 1'b0 && done_oe)[*3] |-> config_strobe_clock_oe)
        else $error("strobe not driven in master or peripheral mode");
    a_slave_takes_strobe: assert property (
        (mode_pins == 2'b10 && !lead_device)[*3] |-> !config_strobe_clock_oe)
        else $error("strobe driven in slave mode");
    a_lead_drives_strobe: assert property (
        (lead_device && mode_pins == 2'b11 && done_oe)[*3] |-> config_strobe_clock_oe)
        else $error("chain lead does not drive strobe");
    a_done_never_high: assert property (done_o == 1'b0)
        else $error("completion pin driven high");
    a_io_after_done: assert property (done_oe |-> !user_io_enable)
        else $error("user I/O live while completion held");
    a_restart_scan_reset: assert property (!program_restart_n [*3] |-> jtag_reset)
        else $error("scan reset missing on restart");
    a_cfg_tristate: assert property (
        (!rd_cfg_n && !user_io_enable)[*4] |-> global_tristate)
        else $error("global tri-state missing during configuration");
endmodule
`default_nettype wire

// file: dv/cfg_host_model.sv
/*
 External configuration host: strobe source in slave mode, completion wire, frame memory.
 Assumes the device strobe enable selects who drives the strobe wire.
*/
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
    input wire logic config_strobe_clock_o,     // Strobe from device
    input wire logic config_strobe_clock_oe,    // Device drives strobe
    input wire logic run,                       // Host clocks a frame
    input wire logic done_oe,                   // Device pulls completion low
    input wire logic hold_done,                 // Host holds completion low
    input wire logic [15:0] frame_addr,         // Readback address
    output logic config_strobe_clock_i,         // Strobe wire level
    output logic done_i,                        // Completion wire level
    output logic [15:0] frame_data              // Readback word
);
    logic ext_clk = 1'b0;
    // Host clock, 160 ns period, stands still outside frames
    always #80 ext_clk = run ? ~ext_clk : 1'b0;
    assign config_strobe_clock_i = config_strobe_clock_oe ? config_strobe_clock_o : ext_clk;
    // Open-drain wire with pull-up
    assign done_i = !(done_oe || hold_done);
    assign frame_data = {frame_addr[7:0], ~frame_addr[7:0]};
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
 Self-checking bench for the configuration pin controller.
 Assumes the host model on the strobe and completion wires.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cfg_pin_params.svh"
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic reset_pin = 1'b0;
    logic program_restart_n = 1'b1;
    logic rd_cfg_n = 1'b1; // Held high through initialisation
    logic [1:0] mode_pins = 2'b10;
    logic lead_device = 1'b0;
    logic load_bit = 1'b0;
    logic init_error = 1'b0;
    logic jtag_active = 1'b0;
    logic tdo_data = 1'b0;
    logic host_irq_req = 1'b0;
    logic [7:0] unused_pins = 8'hA5;
    logic run = 1'b0;
    logic hold_done = 1'b0;
    logic [31:0] rdata, r;
    logic config_strobe_clock_i, config_strobe_clock_o, config_strobe_clock_oe;
    logic done_i, done_o, done_oe, init_status, rd_data_tdo, cfg_irq_n, user_io_enable;
    logic global_tristate, global_set_reset, user_reset_in, jtag_reset;
    logic [15:0] frame_addr, frame_data;
    logic [7:0] io_pullup;
    int n_mismatch = 0;
    int total_checks = 0;
    fpga_config_pin_control dut_u (
        .clk, .sys_rst, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata, .reset_pin,
        .program_restart_n, .rd_cfg_n, .mode_pins, .lead_device, .config_strobe_clock_i,
        .config_strobe_clock_o, .config_strobe_clock_oe, .done_i, .done_o, .done_oe,
        .init_status, .load_bit, .init_error, .jtag_active, .tdo_data, .frame_data,
        .frame_addr, .rd_data_tdo, .host_irq_req, .cfg_irq_n, .unused_pins, .user_io_enable,
        .io_pullup, .global_tristate, .global_set_reset, .user_reset_in, .jtag_reset
    );
    cfg_host_model host_u (
        .config_strobe_clock_o, .config_strobe_clock_oe, .run, .done_oe, .hold_done,
        .frame_addr, .config_strobe_clock_i, .done_i, .frame_data
    );
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask
    task automatic chk_state(input logic [2:0] s);
        rd_reg(4'h1);
        chk(r[2:0], s);
    endtask
    task automatic pulse_load(input int n);
        repeat (n) begin
            @(posedge clk);
            load_bit <= 1'b1;
            @(posedge clk);
            load_bit <= 1'b0;
        end
    endtask
    task automatic t_regs;
        rd_reg(4'h0);
        chk(r, {24'h0, `OPT_DONE_DELAY_RST, `OPT_IO_DELAY_RST});
        wr_reg(4'hF, 32'hFFFF_FFFF);
        rd_reg(4'hF);
        chk(r, 32'h0);
        wr_reg(4'h0, 32'h0000_0523);
        rd_reg(4'h0);
        chk(r, 32'h0000_0523);
        chk_state(cfg_pin_pkg::ST_LOAD);
        chk(init_status, 1'b1);
    endtask
    task automatic t_modes;
        logic g;
        mode_pins <= 2'b00;
        cyc(2);
        g = config_strobe_clock_o;
        cyc(`STROBE_DIV);
        chk(config_strobe_clock_o, !g);
        for (int i = 0; i < 8; i++) begin
            if (i != 3) begin
                mode_pins <= i[1:0];
                lead_device <= i[2];
                cyc(4);
                chk(config_strobe_clock_oe, i[1:0] != 2'b10);
            end
        end
        mode_pins <= 2'b10;
        lead_device <= 1'b0;
    endtask
    task automatic t_restart;
        pulse_load(10);
        init_error <= 1'b1;
        cyc(4);
        chk(cfg_irq_n, 1'b0);
        init_error <= 1'b0;
        program_restart_n <= 1'b0;
        cyc(5);
        chk(jtag_reset, 1'b1);
        chk_state(cfg_pin_pkg::ST_CLEAR);
        program_restart_n <= 1'b1;
        cyc(5);
        chk_state(cfg_pin_pkg::ST_LOAD);
        reset_pin <= 1'b1;
        cyc(5);
        chk_state(cfg_pin_pkg::ST_CLEAR);
        reset_pin <= 1'b0;
        cyc(5);
        chk_state(cfg_pin_pkg::ST_LOAD);
    endtask
    task automatic t_config;
        chk(user_io_enable, 1'b0);
        chk(io_pullup, 8'hFF);
        rd_cfg_n <= 1'b0;
        cyc(5);
        chk(global_tristate, 1'b1);
        rd_cfg_n <= 1'b1;
        pulse_load(`LOAD_BITS - 1);
        cyc(1);
        chk_state(cfg_pin_pkg::ST_LOAD);
        hold_done <= 1'b1;
        run <= 1'b1;
        pulse_load(1);
        cyc(200);
        chk_state(cfg_pin_pkg::ST_WAIT_DONE);
        hold_done <= 1'b0;
        for (int i = 0; i < 600 && user_io_enable !== 1'b1; i++) cyc(1);
        chk(done_oe, 1'b0);
        chk_state(cfg_pin_pkg::ST_USER);
        chk(io_pullup, unused_pins);
        run <= 1'b0;
    endtask
    task automatic t_user;
        reset_pin <= 1'b1;
        cyc(5);
        chk(global_set_reset, 1'b1);
        chk_state(cfg_pin_pkg::ST_USER);
        wr_reg(4'h0, 32'h0000_0123);
        cyc(1);
        chk(user_reset_in, 1'b1);
        chk(global_set_reset, 1'b0);
        reset_pin <= 1'b0;
        host_irq_req <= 1'b1;
        cyc(5);
        chk(cfg_irq_n, 1'b0);
        host_irq_req <= 1'b0;
    endtask
    task automatic t_readback;
        logic [15:0] w;
        rd_cfg_n <= 1'b0;
        cyc(5);
        chk(global_tristate, 1'b0);
        chk(frame_addr, 16'h0000);
        run <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge config_strobe_clock_i);
            w[i] = rd_data_tdo;
        end
        chk(w, 16'h00FF);
        repeat (16) @(posedge config_strobe_clock_i);
        for (int i = 15; i >= 0; i--) begin
            @(posedge config_strobe_clock_i);
            w[i] = rd_data_tdo;
        end
        chk(w, 16'h01FE);
        repeat (16) @(posedge config_strobe_clock_i);
        cyc(6);
        chk(frame_addr, 16'h0002);
        jtag_active <= 1'b1;
        tdo_data <= 1'b1;
        cyc(5);
        chk(rd_data_tdo, 1'b1);
        tdo_data <= 1'b0;
        cyc(5);
        chk(rd_data_tdo, 1'b0);
        rd_cfg_n <= 1'b1;
        wr_reg(4'h0, 32'h0000_0323);
        rd_cfg_n <= 1'b0;
        cyc(5);
        chk(global_tristate, 1'b1);
        chk(user_io_enable, 1'b0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_modes();
        t_restart();
        t_config();
        t_user();
        t_readback();
        test_done();
    end
endmodule
bind fpga_config_pin_control cfg_pin_asserts chk_u (
    .clk, .sys_rst, .rd, .rdata, .mode_pins, .lead_device, .config_strobe_clock_oe,
    .done_o, .done_oe, .user_io_enable, .io_pullup, .unused_pins, .program_restart_n,
    .jtag_reset, .rd_cfg_n, .global_tristate
);
`default_nettype wire
